// ### logic/sbhl_pkg.sv
// Contract
// - host-assisted boot uses only lines 0-9
// - multi-byte values assembled msb first, unaligned
// - line 0 bit 7 selects eeprom size
// - decode three-bit sdram size field
// - two-bit sdram clock field sets memory clock
// - line 0 bit 1 selects eeprom bus speed
// - line 0 bit 0 selects test mode
// - subsystem ids from lines 1 to 4
// - line 9 bit 7 is boot type
// - init, wait pll lock, enable memory paths
package sbhl_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SLOW_HZ         = 100_000;
    localparam int unsigned FAST_HZ         = 400_000;
    // quarter-period of the serial clock in system cycles
    localparam int unsigned SLOW_Q          = CLK_HZ / (SLOW_HZ * 4);
    localparam int unsigned FAST_Q          = CLK_HZ / (FAST_HZ * 4);
    localparam logic [7:0]  DEV_ADDR_WR     = 8'h00_A0;
    localparam logic [7:0]  DEV_ADDR_RD     = 8'h00_A1;
    localparam logic [7:0]  LAST_HOST_LINE  = 8'h00_09;
    localparam logic [7:0]  LAST_AUTO_LINE  = 8'h00_0E;
    localparam logic [7:0]  BASE_B0         = 8'h00_EF;
    localparam logic [7:0]  BASE_B1         = 8'h00_F0;
    localparam logic [7:0]  BASE_B2         = 8'h00_04;
    localparam logic [7:0]  BASE_B3         = 8'h00_00;
    localparam int unsigned BIT_LINES       = 7;
    localparam int unsigned BIT_SPEED       = 1;
    localparam int unsigned BIT_TEST        = 0;
    localparam int unsigned BIT_BOOT        = 7;
    localparam int unsigned BIT_PCICLK      = 6;
    localparam int unsigned BIT_PREF        = 5;
    localparam logic [10:0] MAX_BYTES       = 11'h07_D0;
    typedef enum logic [2:0] {
        SBHL_OP_START = 3'h0,
        SBHL_OP_WBYTE = 3'h1,
        SBHL_OP_RBYTE = 3'h2,
        SBHL_OP_STOP  = 3'h3
    } sbhl_op_type;
endpackage : sbhl_pkg

// ### logic/sbhl_twi.sv
module sbhl_twi
    import sbhl_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // command
    input  wire logic              cmd_valid,
    input  wire sbhl_pkg::sbhl_op_type cmd_op,
    input  wire logic [7:0]        cmd_data,
    input  wire logic              cmd_last,
    input  wire logic              fast,
    output logic                   cmd_ready,
    output logic                   done,
    output logic [7:0]             rd_data,
    output logic                   nack,
    // serial pins
    input  wire logic              scl_in,
    output logic                   scl_oe,
    input  wire logic              sda_in,
    output logic                   sda_oe
);
    import sbhl_pkg::*;
    logic [1:0]  sda_sync_q;
    logic [1:0]  scl_sync_q;
    logic [15:0] tick_q;
    logic [1:0]  phase_q;
    logic [3:0]  bit_q;
    logic        busy_q;
    sbhl_op_type op_q;
    logic [8:0]  sh_q;
    logic        tick;
    logic [15:0] qlen;

    assign qlen      = fast ? 16'(FAST_Q) : 16'(SLOW_Q);
    assign tick      = (tick_q == qlen - 16'h0001);
    assign cmd_ready = !busy_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_sync_q <= 2'h0;
            scl_sync_q <= 2'h0;
        end else begin
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_sync_q <= {scl_sync_q[0], scl_in};
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_q <= 16'h0000;
        end else if (!busy_q || tick) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_q    <= 1'b0;
            op_q      <= SBHL_OP_STOP;
            phase_q   <= 2'h0;
            bit_q     <= 4'h0;
            sh_q      <= 9'h000;
            scl_oe    <= 1'b0;
            sda_oe    <= 1'b0;
            done      <= 1'b0;
            rd_data   <= 8'h00;
            nack      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!busy_q) begin
                if (cmd_valid) begin
                    busy_q    <= 1'b1;
                    op_q      <= cmd_op;
                    phase_q   <= 2'h0;
                    bit_q     <= 4'h0;
                    sh_q      <= (cmd_op == SBHL_OP_WBYTE) ? {cmd_data, 1'b1}
                                                           : 9'h1FF;
                end
            end else if (tick) begin
                phase_q <= phase_q + 2'h1;
                unique case (op_q)
                    SBHL_OP_START: begin
                        unique case (phase_q)
                            2'h0: begin sda_oe <= 1'b0; scl_oe <= 1'b0; end
                            2'h1: sda_oe <= 1'b1;
                            2'h2: scl_oe <= 1'b1;
                            2'h3: begin busy_q <= 1'b0; done <= 1'b1; end
                        endcase
                    end
                    SBHL_OP_STOP: begin
                        unique case (phase_q)
                            2'h0: begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b0;
                            2'h3: begin busy_q <= 1'b0; done <= 1'b1; end
                        endcase
                    end
                    default: begin
                        unique case (phase_q)
                            2'h0: begin
                                // ack or nack of a read byte is chosen from cmd_last: nack on the last line, ack otherwise
                                if (bit_q == 4'h8 && op_q == SBHL_OP_RBYTE) begin
                                    sda_oe <= !cmd_last;
                                end else begin
                                    sda_oe <= !sh_q[8];
                                end
                            end
                            2'h1: scl_oe <= 1'b0;
                            2'h2: begin
                                if (scl_sync_q[1]) begin
                                    sh_q <= {sh_q[7:0], sda_sync_q[1]};
                                end else begin
                                    phase_q <= phase_q;
                                end
                            end
                            2'h3: begin
                                scl_oe <= 1'b1;
                                bit_q  <= bit_q + 4'h1;
                                if (bit_q == 4'h7) begin
                                    // byte complete before the ack slot
                                    rd_data <= sh_q[7:0];
                                end
                                if (bit_q == 4'h8) begin
                                    busy_q  <= 1'b0;
                                    done    <= 1'b1;
                                    nack    <= sh_q[0] && (op_q == SBHL_OP_WBYTE);
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end
endmodule : sbhl_twi

// ### logic/sbhl_loader.sv
module sbhl_loader
    import sbhl_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // serial eeprom pins
    input  wire logic              scl_in,
    output logic                   scl_oe,
    input  wire logic              sda_in,
    output logic                   sda_oe,
    // clock system
    input  wire logic              pll_lock,
    // decoded line 0
    output logic                   eeprom_large,
    output logic [2:0]             sdram_size_code,
    output logic [6:0]             sdram_size_mb,
    output logic [1:0]             sdram_clk_sel,
    output logic                   eeprom_fast,
    output logic                   test_mode,
    // configuration values
    output logic [15:0]            subsystem_id,
    output logic [15:0]            subsystem_vendor_id,
    output logic [19:0]            memory_config_word,
    output logic [7:0]             clock_multiplier_settings,
    output logic                   boot_autonomous,
    output logic                   internal_pci_clk_en,
    output logic                   sdram_prefetchable,
    output logic [10:0]            program_byte_count,
    output logic [31:0]            register_aperture_base,
    // status
    output logic                   config_valid,
    output logic                   memory_paths_en,
    output logic                   main_processor_reset,
    output logic                   header_error,
    output logic                   eeprom_error
);
    import sbhl_pkg::*;
    typedef enum logic [3:0] {
        SBHL_S_START  = 4'h0,
        SBHL_S_DEVW   = 4'h1,
        SBHL_S_ADDRH  = 4'h2,
        SBHL_S_ADDRL  = 4'h3,
        SBHL_S_RSTART = 4'h4,
        SBHL_S_DEVR   = 4'h5,
        SBHL_S_READ   = 4'h6,
        SBHL_S_STOP   = 4'h7,
        SBHL_S_LOCK   = 4'h8,
        SBHL_S_IDLE   = 4'h9
    } sbhl_state_type;

    sbhl_state_type state_q;
    logic [7:0]     line_q;
    logic [7:0]     last_line;
    logic           issued_q;
    logic           cmd_valid;
    sbhl_op_type    cmd_op;
    logic [7:0]     cmd_data;
    logic           cmd_ready;
    logic           done;
    logic [7:0]     rd_data;
    logic           nack;
    logic           cmd_last;
    logic           boot_live;
    logic [1:0]     lock_sync_q;

    // host-assisted stops after line 9; line 9 decides from its own boot bit
    assign boot_live = (line_q == LAST_HOST_LINE) ? rd_data[BIT_BOOT] : boot_autonomous;
    assign last_line = boot_live ? LAST_AUTO_LINE : LAST_HOST_LINE;
    assign cmd_last  = (line_q == last_line);

    sbhl_twi u_twi (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_data  (cmd_data),
        .cmd_last  (cmd_last),
        .fast      (eeprom_fast),
        .cmd_ready (cmd_ready),
        .done      (done),
        .rd_data   (rd_data),
        .nack      (nack),
        .scl_in    (scl_in),
        .scl_oe    (scl_oe),
        .sda_in    (sda_in),
        .sda_oe    (sda_oe)
    );

    assign cmd_valid = !issued_q && (state_q != SBHL_S_LOCK) && (state_q != SBHL_S_IDLE);

    // pll lock comes from another domain
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_sync_q <= 2'h0;
        end else begin
            lock_sync_q <= {lock_sync_q[0], pll_lock};
        end
    end

    always_comb begin
        cmd_op   = SBHL_OP_WBYTE;
        cmd_data = 8'h00;
        unique case (state_q)
            SBHL_S_START,
            SBHL_S_RSTART: cmd_op = SBHL_OP_START;
            SBHL_S_DEVW:   cmd_data = DEV_ADDR_WR;
            SBHL_S_ADDRH:  cmd_data = 8'h00;
            SBHL_S_ADDRL:  cmd_data = 8'h00;
            SBHL_S_DEVR:   cmd_data = DEV_ADDR_RD;
            SBHL_S_READ:   cmd_op = SBHL_OP_RBYTE;
            SBHL_S_STOP:   cmd_op = SBHL_OP_STOP;
            default:       cmd_op = SBHL_OP_STOP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q  <= SBHL_S_START;
            issued_q <= 1'b0;
            line_q   <= 8'h00;
        end else begin
            if (cmd_valid && cmd_ready) begin
                issued_q <= 1'b1;
            end
            if (done) begin
                issued_q <= 1'b0;
                unique case (state_q)
                    SBHL_S_START:  state_q <= SBHL_S_DEVW;
                    SBHL_S_DEVW:   state_q <= nack ? SBHL_S_STOP
                                            : (eeprom_large ? SBHL_S_ADDRH : SBHL_S_ADDRL);
                    SBHL_S_ADDRH:  state_q <= nack ? SBHL_S_STOP : SBHL_S_ADDRL;
                    SBHL_S_ADDRL:  state_q <= nack ? SBHL_S_STOP : SBHL_S_RSTART;
                    SBHL_S_RSTART: state_q <= SBHL_S_DEVR;
                    SBHL_S_DEVR:   state_q <= nack ? SBHL_S_STOP : SBHL_S_READ;
                    SBHL_S_READ: begin
                        line_q <= line_q + 8'h01;
                        if (cmd_last) begin
                            state_q <= SBHL_S_STOP;
                        end
                    end
                    SBHL_S_STOP:   state_q <= SBHL_S_LOCK;
                    default:       state_q <= state_q;
                endcase
            end else if (state_q == SBHL_S_LOCK && lock_sync_q[1]) begin
                state_q <= SBHL_S_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            eeprom_error <= 1'b0;
        end else if (done && nack && state_q != SBHL_S_READ) begin
            eeprom_error <= 1'b1;
        end
    end

    // header bytes, multi-byte values msb first
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            eeprom_large              <= 1'b0;
            sdram_size_code           <= 3'h0;
            sdram_clk_sel             <= 2'h0;
            eeprom_fast               <= 1'b0;
            test_mode                 <= 1'b0;
            subsystem_id              <= 16'h0000;
            subsystem_vendor_id       <= 16'h0000;
            memory_config_word        <= 20'h0_0000;
            clock_multiplier_settings <= 8'h00;
            boot_autonomous           <= 1'b0;
            internal_pci_clk_en       <= 1'b0;
            sdram_prefetchable        <= 1'b0;
            program_byte_count        <= 11'h000;
            register_aperture_base    <= 32'h0000_0000;
        end else if (done && state_q == SBHL_S_READ) begin
            unique case (line_q)
                8'h00: begin
                    eeprom_large    <= rd_data[BIT_LINES];
                    sdram_size_code <= rd_data[6:4];
                    sdram_clk_sel   <= rd_data[3:2];
                    eeprom_fast     <= rd_data[BIT_SPEED];
                    test_mode       <= rd_data[BIT_TEST];
                end
                8'h01: subsystem_id[15:8]        <= rd_data;
                8'h02: subsystem_id[7:0]         <= rd_data;
                8'h03: subsystem_vendor_id[15:8] <= rd_data;
                8'h04: subsystem_vendor_id[7:0]  <= rd_data;
                8'h05: memory_config_word[19:16] <= rd_data[3:0];
                8'h06: memory_config_word[15:8]  <= rd_data;
                8'h07: memory_config_word[7:0]   <= rd_data;
                8'h08: clock_multiplier_settings <= rd_data;
                8'h09: begin
                    boot_autonomous           <= rd_data[BIT_BOOT];
                    internal_pci_clk_en       <= rd_data[BIT_PCICLK];
                    sdram_prefetchable        <= rd_data[BIT_PREF];
                    program_byte_count[10:8]  <= rd_data[2:0];
                end
                8'h0A: program_byte_count[7:0]     <= rd_data;
                8'h0B: register_aperture_base[31:24] <= rd_data;
                8'h0C: register_aperture_base[23:16] <= rd_data;
                8'h0D: register_aperture_base[15:8]  <= rd_data;
                8'h0E: register_aperture_base[7:0]   <= rd_data;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (sdram_size_code)
            3'h0, 3'h1: sdram_size_mb = 7'd1;
            3'h2:       sdram_size_mb = 7'd2;
            3'h3:       sdram_size_mb = 7'd4;
            3'h4:       sdram_size_mb = 7'd8;
            3'h5:       sdram_size_mb = 7'd16;
            3'h6:       sdram_size_mb = 7'd32;
            3'h7:       sdram_size_mb = 7'd64;
        endcase
    end

    assign config_valid    = (state_q == SBHL_S_LOCK) || (state_q == SBHL_S_IDLE);
    assign memory_paths_en = (state_q == SBHL_S_IDLE);
    // processor stays in reset in both modes; program load is outside this block
    assign main_processor_reset = 1'b1;

    // image sanity: fixed base and byte count
    assign header_error = config_valid && boot_autonomous &&
        ((register_aperture_base != {BASE_B0, BASE_B1, BASE_B2, BASE_B3}) ||
         (program_byte_count[1:0] != 2'h0) ||
         (program_byte_count > MAX_BYTES));
endmodule : sbhl_loader

// ### bench/sbhl_loader_asserts.sv
module sbhl_loader_asserts
    import sbhl_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // watched ports
    input wire logic        scl_oe,
    input wire logic        pll_lock,
    input wire logic        eeprom_fast,
    input wire logic [2:0]  sdram_size_code,
    input wire logic [6:0]  sdram_size_mb,
    input wire logic [15:0] subsystem_id,
    input wire logic        boot_autonomous,
    input wire logic [10:0] program_byte_count,
    input wire logic [31:0] register_aperture_base,
    input wire logic        config_valid,
    input wire logic        memory_paths_en,
    input wire logic        main_processor_reset,
    input wire logic        header_error,
    input wire logic        eeprom_error
);
    logic        prev_q;
    logic [2:0]  fcnt_q;
    logic [15:0] seg_q;
    wire         edge_w = scl_oe != prev_q;
    // length of each serial clock level
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            seg_q  <= 16'h0000;
        end else begin
            prev_q <= scl_oe;
            seg_q  <= edge_w ? 16'h0001 : seg_q + 16'h0001;
        end
    end
    // serial clock edges since fast speed chosen
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fcnt_q <= 3'h0;
        end else if (edge_w && eeprom_fast && fcnt_q != 3'h4) begin
            fcnt_q <= fcnt_q + 3'h1;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_proc_held: assert property (main_processor_reset)
        else $error("processor released by loader");
    a_size_decode: assert property (sdram_size_mb == ((sdram_size_code < 3'h2) ? 7'h01 :
        (7'h01 << (sdram_size_code - 3'h1)))) else $error("sdram size decode wrong");
    a_slow_start: assert property (edge_w && !eeprom_fast |-> seg_q >= SLOW_Q - 2)
        else $error("serial clock too fast before line 0");
    a_fast_speed: assert property (edge_w && fcnt_q == 3'h4 |-> seg_q <= 4 * FAST_Q)
        else $error("serial clock not at fast speed");
    a_config_stands: assert property (config_valid |=> config_valid &&
        $stable(subsystem_id) && $stable(register_aperture_base)) else $error("config changed");
    a_host_noerr: assert property (config_valid && !boot_autonomous |-> !header_error)
        else $error("header error in host boot");
    a_base_check: assert property ($rose(config_valid) && boot_autonomous &&
        register_aperture_base != 32'hEFF0_0400 |-> ##[0:2] header_error)
        else $error("bad aperture base not flagged");
    a_count_check: assert property ($rose(config_valid) && boot_autonomous &&
        program_byte_count[1:0] != 2'h0 |-> ##[0:2] header_error)
        else $error("bad byte count not flagged");
    a_paths_lock: assert property ($rose(memory_paths_en) |-> pll_lock)
        else $error("memory paths enabled without lock");
    a_paths_order: assert property (memory_paths_en |-> config_valid || eeprom_error)
        else $error("memory paths enabled before init");
endmodule : sbhl_loader_asserts

bind sbhl_loader sbhl_loader_asserts u_sbhl_loader_asserts (
    .sys_clk, .reset_n, .scl_oe, .pll_lock, .eeprom_fast, .sdram_size_code, .sdram_size_mb,
    .subsystem_id, .boot_autonomous, .program_byte_count, .register_aperture_base,
    .config_valid, .memory_paths_en, .main_processor_reset, .header_error, .eeprom_error
);

// ### bench/sbhl_eeprom_model.sv
module sbhl_eeprom_model (
    // serial pins
    input  wire logic  scl,
    input  wire logic  sda,
    output logic       sda_pull,
    // control and observation
    input  wire logic  nack_all,
    output logic [7:0] first_ptr,
    output logic [7:0] last_line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:255];
    logic [7:0] sh;
    logic [7:0] ptr;
    int         bits;
    logic       first;
    logic       go_tx;
    logic       tx;
    initial begin
        sda_pull = 1'b0;
        bits = 0;
        tx = 1'b0;
        go_tx = 1'b0;
        first = 1'b0;
    end
    // start or stop restarts byte framing
    always @(sda) begin
        if (scl === 1'b1) begin
            bits = 0;
            tx = 1'b0;
            go_tx = 1'b0;
            first = 1'b1;
            sda_pull = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (bits == 8) begin
            if (tx && sda) begin
                tx = 1'b0;
                last_line = ptr;
            end else if (tx) begin
                ptr = ptr + 8'h01;
            end
            tx = tx | go_tx;
            go_tx = 1'b0;
            bits = 0;
        end else begin
            sh = {sh[6:0], sda};
            bits = bits + 1;
            if (bits == 8 && !tx && first) begin
                go_tx = sh[0] && !nack_all;
                first = 1'b0;
            end else if (bits == 8 && !tx) begin
                ptr = sh;
                first_ptr = sh;
            end
        end
    end
    // released line reads high through the pull-up
    always @(negedge scl) begin
        if (tx && bits < 8) sda_pull = ~mem[ptr][7 - bits];
        else if (!tx && bits == 8) sda_pull = !nack_all;
        else sda_pull = 1'b0;
    end
endmodule : sbhl_eeprom_model

// ### bench/sbhl_loader_tb_top.sv
module sbhl_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset_n, pll_lock, nack_all, sda_pull, scl_oe, sda_oe;
    logic eeprom_large, eeprom_fast, test_mode, boot_autonomous, internal_pci_clk_en;
    logic sdram_prefetchable, config_valid, memory_paths_en, main_processor_reset;
    logic header_error, eeprom_error;
    logic [2:0]  sdram_size_code;
    logic [6:0]  sdram_size_mb;
    logic [1:0]  sdram_clk_sel;
    logic [15:0] subsystem_id, subsystem_vendor_id;
    logic [19:0] memory_config_word;
    logic [7:0]  clock_multiplier_settings, first_ptr, last_line;
    logic [10:0] program_byte_count;
    logic [31:0] register_aperture_base;
    int          mismatches, num_checks;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | sda_pull);
    sbhl_loader u_sbhl_loader (.sys_clk, .reset_n, .scl_in(scl), .scl_oe, .sda_in(sda),
        .sda_oe, .pll_lock, .eeprom_large, .sdram_size_code, .sdram_size_mb, .sdram_clk_sel,
        .eeprom_fast, .test_mode, .subsystem_id, .subsystem_vendor_id, .memory_config_word,
        .clock_multiplier_settings, .boot_autonomous, .internal_pci_clk_en,
        .sdram_prefetchable, .program_byte_count, .register_aperture_base, .config_valid,
        .memory_paths_en, .main_processor_reset, .header_error, .eeprom_error);
    sbhl_eeprom_model u_sbhl_eeprom_model (.scl, .sda, .sda_pull, .nack_all, .first_ptr,
        .last_line);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic boot(input logic [119:0] img, input logic nk);
        int n;
        for (int i = 0; i < 15; i++) u_sbhl_eeprom_model.mem[i] = img[119 - 8 * i -: 8];
        u_sbhl_eeprom_model.last_line = 8'hFF;
        u_sbhl_eeprom_model.first_ptr = 8'hFF;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        pll_lock <= 1'b0;
        nack_all <= nk;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        n = 0;
        while (config_valid !== 1'b1 && eeprom_error !== 1'b1 && n < 60000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 60000) begin
            mismatches++;
            $display("FAIL at %0t: boot did not finish", $time);
            end_of_test();
        end
        repeat (4) @(posedge sys_clk);
    endtask : boot
    task automatic test_nack();
        boot(120'h02_0000_0000_0000_0000_8008_EFF0_0400, 1'b1);
        chk(eeprom_error, 1);
        chk(config_valid, 0);
        $display("test nack done");
    endtask : test_nack
    task automatic test_host();
        boot(120'hDB_1234_5678_FABC_DE5A_4700_0000_0000, 1'b0);
        chk({eeprom_large, sdram_size_code, sdram_clk_sel, eeprom_fast, test_mode}, 8'hDB);
        chk(sdram_size_mb, 16);
        chk({subsystem_id, subsystem_vendor_id}, 32'h1234_5678);
        chk({memory_config_word, clock_multiplier_settings}, 28'hABC_DE5A);
        chk({boot_autonomous, internal_pci_clk_en, sdram_prefetchable}, 3'h2);
        chk({first_ptr, last_line}, 16'h0009);
        chk(register_aperture_base, 0);
        chk(header_error, 0);
        chk(memory_paths_en, 0);
        pll_lock <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({memory_paths_en, main_processor_reset}, 2'h3);
        $display("test host done");
    endtask : test_host
    task automatic test_auto();
        // fixed aperture base and a byte count of 500 in the image
        boot(120'h24_A55A_0FF0_0321_4387_A1F4_EFF0_0400, 1'b0);
        chk({eeprom_large, sdram_size_code, sdram_clk_sel, eeprom_fast, test_mode}, 8'h24);
        chk(sdram_size_mb, 2);
        chk({subsystem_id, subsystem_vendor_id}, 32'hA55A_0FF0);
        chk({memory_config_word, clock_multiplier_settings}, 28'h321_4387);
        chk({boot_autonomous, internal_pci_clk_en, sdram_prefetchable}, 3'h5);
        chk(program_byte_count, 11'h1F4);
        chk(register_aperture_base, 32'hEFF0_0400);
        chk({first_ptr, last_line, header_error}, 17'h0001C);
        $display("test autonomous done");
    endtask : test_auto
    task automatic test_bad();
        boot(120'h02_0000_0000_0000_0000_8006_EFF0_0400, 1'b0);
        chk({header_error, sdram_size_mb}, 8'h81);
        boot(120'h02_0000_0000_0000_0000_8008_EFF0_0500, 1'b0);
        chk(header_error, 1);
        chk(register_aperture_base, 32'hEFF0_0500);
        $display("test bad header done");
    endtask : test_bad
    initial begin
        reset_n = 1'b0;
        pll_lock = 1'b0;
        nack_all = 1'b0;
        mismatches = 0;
        num_checks = 0;
        repeat (4) @(posedge sys_clk);
        test_nack();
        test_host();
        test_bad();
        test_auto();
        end_of_test();
    end
endmodule : sbhl_loader_tb_top
